/* sfs_top.sv */
// Serial port FIFO status, interrupt test and data port, APB slave.
// Assumes the serializer presents pulses for frame words; one clock domain.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ns
module sfs_top
  import sfs_pkg::*;
#(
  parameter int DEPTH = SFS_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic serBusy,
  input wire logic serTxPop,
  output logic [31:0] serTxData,
  output logic serTxValid,
  input wire logic serRxPush,
  input wire logic [31:0] serRxData,
  output logic portEnable,
  output logic [4:0] sampleSizeM1,
  output logic irqReq,
  output logic dmaRxReq,
  output logic dmaTxReq
);
  typedef struct packed {
    logic en;
    logic pack;
    logic [4:0] size;
    logic tur;
    logic turMask;
    logic [3:0] rxThr;
    logic [3:0] txThr;
    logic ror;
    logic tRor;
    logic tRfs;
    logic tTfs;
    logic rdAvail;
    logic [31:0] rdata;
  } sfs_state_t;

  sfs_state_t st_reg, st_next;
  sfs_apb_req_t req;
  logic access, wrEn, rdEn, setupRd;
  logic [4:0] rxCnt, txCnt;
  logic [31:0] rxHead, txLeft, rxMask;
  logic txFull, rxFull, rxEmpty, txEmpty;
  logic rxPushQ, txPushQ, txPopQ, rxPopQ, fifoClr;
  logic rfs, tfs;
  logic [31:0] statusWord, ctrlWord, thrWord, itestWord, rdMux;
  logic mapped;

  assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: paddr, pwdata: pwdata};
  // Zero-wait slave: every access completes in its first access cycle
  assign access = req.psel && req.penable;
  assign wrEn = access && req.pwrite;
  assign rdEn = access && !req.pwrite;
  // Read data is registered in the setup cycle, so it already stands at the access edge
  assign setupRd = req.psel && !req.penable && !req.pwrite;
  assign pready = 1'b1;
  assign mapped = (req.paddr == SFS_ADDR_CTRL) || (req.paddr == SFS_ADDR_THR) ||
    (req.paddr == SFS_ADDR_STATUS) || (req.paddr == SFS_ADDR_ITEST) ||
    (req.paddr == SFS_ADDR_DATA);
  assign pslverr = access && !mapped;
  assign prdata = st_reg.rdata;

  assign txFull = txCnt == 5'(DEPTH);
  assign rxFull = rxCnt == 5'(DEPTH);
  assign rxEmpty = rxCnt == '0;
  assign txEmpty = txCnt == '0;

  assign fifoClr = !st_reg.en;

  assign txPushQ = wrEn && req.paddr == SFS_ADDR_DATA && !txFull && st_reg.en;
  assign txPopQ = serTxPop && !txEmpty;
  assign rxPushQ = serRxPush && !rxFull && st_reg.en;
  // read path out of receive holding
  // Pop only what was captured, so a word pushed during setup is not lost
  assign rxPopQ = rdEn && req.paddr == SFS_ADDR_DATA && !rxEmpty && st_reg.rdAvail;

  sfs_just uJust (
    .din(req.pwdata),
    .sizeM1(st_reg.size),
    .leftOut(txLeft),
    .maskOut(rxMask)
  );

  sfs_fifo #(.WIDTH(SFS_DATA_W), .DEPTH(DEPTH)) uTxFifo (
    .clk(clk),
    .arst_n(arst_n),
    .clr(fifoClr),
    .push(txPushQ),
    .din(txLeft),
    .pop(txPopQ),
    .dout(serTxData),
    .count(txCnt)
  );

  sfs_fifo #(.WIDTH(SFS_DATA_W), .DEPTH(DEPTH)) uRxFifo (
    .clk(clk),
    .arst_n(arst_n),
    .clr(fifoClr),
    .push(rxPushQ),
    .din(serRxData & rxMask),
    .pop(rxPopQ),
    .dout(rxHead),
    .count(rxCnt)
  );

  assign serTxValid = !txEmpty && st_reg.en;
  assign portEnable = st_reg.en;
  assign sampleSizeM1 = st_reg.size;

  assign rfs = st_reg.en && (rxCnt > {1'b0, st_reg.rxThr});
  // transmit service at or below threshold plus one
  assign tfs = st_reg.en && (txCnt <= ({1'b0, st_reg.txThr} + 5'h01));

  always_comb begin
    statusWord = '0;
    statusWord[SFS_ST_TUR] = st_reg.tur;
    // entries minus one wraps to 0xF when empty
    statusWord[SFS_ST_RFL_LO +: SFS_LVL_W] = 4'(rxCnt - 5'h01);
    // transmit count, full wraps to zero
    statusWord[SFS_ST_TFL_LO +: SFS_LVL_W] = txCnt[SFS_LVL_W-1:0];
    statusWord[SFS_ST_ROR] = st_reg.ror;
    statusWord[SFS_ST_RFS] = rfs;
    statusWord[SFS_ST_TFS] = tfs;
    statusWord[SFS_ST_BSY] = serBusy && st_reg.en;
    statusWord[SFS_ST_RNE] = !rxEmpty;
    statusWord[SFS_ST_TNF] = !txFull;
  end

  always_comb begin
    ctrlWord = '0;
    ctrlWord[SFS_CTRL_EN] = st_reg.en;
    ctrlWord[SFS_CTRL_PACK] = st_reg.pack;
    ctrlWord[SFS_SIZE_HI:SFS_SIZE_LO] = st_reg.size;
    ctrlWord[SFS_ST_TUR] = st_reg.turMask;
    thrWord = '0;
    thrWord[SFS_RXT_LO +: SFS_LVL_W] = st_reg.rxThr;
    thrWord[SFS_TXT_LO +: SFS_LVL_W] = st_reg.txThr;
    itestWord = '0;
    itestWord[SFS_IT_ROR] = st_reg.tRor;
    itestWord[SFS_IT_RFS] = st_reg.tRfs;
    itestWord[SFS_IT_TFS] = st_reg.tTfs;
    case (req.paddr)
      SFS_ADDR_CTRL: rdMux = ctrlWord;
      SFS_ADDR_THR: rdMux = thrWord;
      SFS_ADDR_STATUS: rdMux = statusWord;
      SFS_ADDR_ITEST: rdMux = itestWord;
      SFS_ADDR_DATA: rdMux = rxHead;
      default: rdMux = '0;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    if (setupRd) begin
      st_next.rdata = rdMux;
      st_next.rdAvail = !rxEmpty;
    end
    if (wrEn) begin
      case (req.paddr)
        SFS_ADDR_CTRL: begin
          st_next.en = req.pwdata[SFS_CTRL_EN];
          st_next.pack = req.pwdata[SFS_CTRL_PACK];
          st_next.size = req.pwdata[SFS_SIZE_HI:SFS_SIZE_LO];
          st_next.turMask = req.pwdata[SFS_ST_TUR];
        end
        SFS_ADDR_THR: begin
          st_next.rxThr = req.pwdata[SFS_RXT_LO +: SFS_LVL_W];
          st_next.txThr = req.pwdata[SFS_TXT_LO +: SFS_LVL_W];
        end
        SFS_ADDR_ITEST: begin
          st_next.tRor = req.pwdata[SFS_IT_ROR];
          st_next.tRfs = req.pwdata[SFS_IT_RFS];
          st_next.tTfs = req.pwdata[SFS_IT_TFS];
        end
        SFS_ADDR_STATUS: begin
          if (req.pwdata[SFS_ST_ROR]) st_next.ror = 1'b0;
          if (req.pwdata[SFS_ST_TUR]) st_next.tur = 1'b0;
        end
        default: st_next.rdata = st_reg.rdata;
      endcase
    end
    // overrun and underrun set; set wins over clear
    if (serRxPush && rxFull && st_reg.en) st_next.ror = 1'b1;
    if (serTxPop && txEmpty && st_reg.en) st_next.tur = 1'b1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
      st_reg.size <= SFS_SIZE_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign irqReq = st_reg.ror || st_reg.tRor || rfs || tfs || st_reg.tRfs || st_reg.tTfs ||
    (st_reg.tur && !st_reg.turMask);
  assign dmaRxReq = rfs || st_reg.tRfs;
  assign dmaTxReq = tfs || st_reg.tTfs;
endmodule : sfs_top

/* sfs_pkg.sv */
// Package for the serial port FIFO status block: register map, field layout, reset values.
// Shared by the top module and its two FIFO instances.
package sfs_pkg;
  localparam int SFS_DATA_W = 32;
  localparam int SFS_DEPTH = 16;
  localparam int SFS_LVL_W = 4;
  localparam int SFS_CNT_W = 5;
  // Register byte addresses
  localparam logic [7:0] SFS_ADDR_CTRL = 8'h00;
  localparam logic [7:0] SFS_ADDR_THR = 8'h04;
  localparam logic [7:0] SFS_ADDR_STATUS = 8'h08;
  localparam logic [7:0] SFS_ADDR_ITEST = 8'h0c;
  localparam logic [7:0] SFS_ADDR_DATA = 8'h10;
  // Control register fields
  localparam int SFS_CTRL_EN = 0;
  localparam int SFS_CTRL_PACK = 1;
  localparam int SFS_SIZE_LO = 8;
  localparam int SFS_SIZE_HI = 12;
  localparam logic [4:0] SFS_SIZE_RST = 5'h1f;
  // Threshold register fields
  localparam int SFS_RXT_LO = 0;
  localparam int SFS_TXT_LO = 8;
  // Status register fields
  localparam int SFS_ST_TUR = 21;
  localparam int SFS_ST_RFL_LO = 12;
  localparam int SFS_ST_TFL_LO = 8;
  localparam int SFS_ST_ROR = 7;
  localparam int SFS_ST_RFS = 6;
  localparam int SFS_ST_TFS = 5;
  localparam int SFS_ST_BSY = 4;
  localparam int SFS_ST_RNE = 3;
  localparam int SFS_ST_TNF = 2;
  // Interrupt test fields
  localparam int SFS_IT_ROR = 7;
  localparam int SFS_IT_RFS = 6;
  localparam int SFS_IT_TFS = 5;
  localparam logic [3:0] SFS_RFL_RST = 4'hf;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } sfs_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sfs_apb_rsp_t;
endpackage : sfs_pkg

/* sfs_fifo.sv */
// Synchronous FIFO used for both the transmit and the receive queue.
// Assumes push is ignored when full and pop when empty; clr empties it to zero.
`timescale 1ns/1ns
module sfs_fifo
  import sfs_pkg::*;
#(
  parameter int WIDTH = SFS_DATA_W,
  parameter int DEPTH = SFS_DEPTH,
  parameter int AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clr,
  input wire logic push,
  input wire logic [WIDTH-1:0] din,
  input wire logic pop,
  output logic [WIDTH-1:0] dout,
  output logic [AW:0] count
);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } sfs_fifo_st_t;

  sfs_fifo_st_t st_reg, st_next;
  logic [WIDTH-1:0] mem [DEPTH];
  logic doPush, doPop;

  assign doPush = push && (st_reg.cnt != (AW+1)'(DEPTH));
  assign doPop = pop && (st_reg.cnt != '0);
  assign dout = mem[st_reg.rp];
  assign count = st_reg.cnt;

  always_comb begin
    st_next = st_reg;
    if (clr) begin
      st_next = '0;
    end else begin
      if (doPush) st_next.wp = st_reg.wp + 1'b1;
      if (doPop) st_next.rp = st_reg.rp + 1'b1;
      if (doPush && !doPop) st_next.cnt = st_reg.cnt + 1'b1;
      if (doPop && !doPush) st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) st_reg <= '0;
    else st_reg <= st_next;
  end

  // Storage is cleared with the pointers so stale data never reappears
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : gEntry
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) mem[i] <= '0;
        else if (clr) mem[i] <= '0;
        else if (doPush && st_reg.wp == AW'(i)) mem[i] <= din;
      end
    end
  endgenerate
endmodule : sfs_fifo

/* sfs_just.sv */
// Justification helper: left-justifies a right-justified sample of a given size.
// Pure combinational; size is bits minus one.
`timescale 1ns/1ns
module sfs_just
  import sfs_pkg::*;
(
  input wire logic [31:0] din,
  input wire logic [4:0] sizeM1,
  output logic [31:0] leftOut,
  output logic [31:0] maskOut
);
  logic [4:0] shamt;
  assign shamt = 5'h1f - sizeM1;
  // Unused upper bits fall off the top of the shift
  assign leftOut = din << shamt;
  assign maskOut = 32'hffffffff >> shamt;
endmodule : sfs_just

/* sfs_top_monitor.sv */
// Port-level checker for sfs_top, attached by bind.
// Assumes one clock domain and a zero-wait APB slave.
`timescale 1ns/1ns
module sfs_top_monitor
  import sfs_pkg::*;
#(
  parameter int DEPTH = SFS_DEPTH
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serTxPop,
  input wire logic serTxValid,
  input wire logic serRxPush,
  input wire logic portEnable,
  input wire logic irqReq,
  input wire logic dmaRxReq,
  input wire logic dmaTxReq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  logic acc;
  logic mapped;
  logic itw;
  assign acc = psel && penable;
  assign mapped = paddr inside {SFS_ADDR_CTRL, SFS_ADDR_THR, SFS_ADDR_STATUS,
                                SFS_ADDR_ITEST, SFS_ADDR_DATA};
  assign itw = acc && pwrite && paddr == SFS_ADDR_ITEST;
  a_ready_high: assert property (pready) else $error("pready low");
  a_err_map: assert property (acc |-> pslverr == !mapped) else $error("slverr wrong");
  a_err_idle: assert property (!acc |-> !pslverr) else $error("slverr outside access");
  a_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_test_tx: assert property (itw && pwdata[SFS_IT_TFS] |=> dmaTxReq && irqReq)
    else $error("tx test request missing");
  a_test_rx: assert property (itw && pwdata[SFS_IT_RFS] |=> dmaRxReq && irqReq)
    else $error("rx test request missing");
  a_test_ovr: assert property (itw && pwdata[SFS_IT_ROR] |=> irqReq)
    else $error("overrun test irq missing");
  a_ovr_nodma: assert property (itw && pwdata[SFS_IT_ROR] && !pwdata[SFS_IT_RFS] &&
    !pwdata[SFS_IT_TFS] && !portEnable |=> !dmaRxReq && !dmaTxReq)
    else $error("overrun test raised dma");
  a_svc_irq: assert property (dmaRxReq || dmaTxReq |-> irqReq)
    else $error("service request without irq");
  a_off_silent: assert property (!portEnable |-> !serTxValid)
    else $error("tx valid while disabled");
  a_en_follow: assert property (acc && pwrite && paddr == SFS_ADDR_CTRL
    |=> portEnable == $past(pwdata[SFS_CTRL_EN])) else $error("enable not written");
  c_itest: cover property (itw);
  c_pop: cover property (serTxPop && serTxValid);
  c_push: cover property (serRxPush);
endmodule : sfs_top_monitor

bind sfs_top sfs_top_monitor #(.DEPTH(DEPTH)) u_mon (.clk(clk), .arst_n(arst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .serTxPop(serTxPop),
  .serTxValid(serTxValid), .serRxPush(serRxPush), .portEnable(portEnable),
  .irqReq(irqReq), .dmaRxReq(dmaRxReq), .dmaTxReq(dmaTxReq));

/* sfs_ser_model.sv */
// Serial-side model: takes transmit words and delivers received words.
// Driven by the bench through its tasks; pulses are one clock wide.
`timescale 1ns/1ns
module sfs_ser_model (
  input wire logic clk,
  input wire logic [31:0] serTxData,
  input wire logic serTxValid,
  output logic serTxPop,
  output logic serRxPush,
  output logic [31:0] serRxData,
  output logic serBusy
);
  initial begin
    serTxPop = 1'b0;
    serRxPush = 1'b0;
    serRxData = 32'h5a5a5a5a;
    serBusy = 1'b0;
  end
  // pops even when empty, on purpose
  task automatic popWord(output logic [31:0] d, output logic v);
    @(posedge clk);
    d = serTxData;
    v = serTxValid;
    serTxPop <= 1'b1;
    @(posedge clk);
    serTxPop <= 1'b0;
  endtask : popWord
  // upper bits carry junk; data line inverted once released
  task automatic pushWord(input logic [31:0] d);
    @(posedge clk);
    serRxData <= d;
    serRxPush <= 1'b1;
    @(posedge clk);
    serRxPush <= 1'b0;
    serRxData <= ~d;
  endtask : pushWord
endmodule : sfs_ser_model

/* sfs_top_tb.sv */
// Self-checking bench for sfs_top: APB master tasks and a serial model.
// Assumes read data stands at the access edge, where pready is sampled high.
`timescale 1ns/1ns
module sfs_top_tb;
  import sfs_pkg::*;
  logic clk, arstN, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, serTxData, serRxData;
  logic [4:0] sizeM1;
  logic serTxPop, serTxValid, serRxPush, serBusy, portEnable, irqReq, dmaRxReq, dmaTxReq;
  int nMismatch, samplesChecked;
  sfs_top #(.DEPTH(16)) u_dut (.clk(clk), .arst_n(arstN), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serBusy(serBusy), .serTxPop(serTxPop), .serTxData(serTxData),
    .serTxValid(serTxValid), .serRxPush(serRxPush), .serRxData(serRxData),
    .portEnable(portEnable), .sampleSizeM1(sizeM1), .irqReq(irqReq), .dmaRxReq(dmaRxReq),
    .dmaTxReq(dmaTxReq));
  sfs_ser_model u_ser (.clk(clk), .serTxData(serTxData), .serTxValid(serTxValid),
    .serTxPop(serTxPop), .serRxPush(serRxPush), .serRxData(serRxData), .serBusy(serBusy));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic stopTest();
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stopTest
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge lets registered outputs settle before the caller compares them
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic e;
    apb(1'b1, a, d, rd, e);
  endtask : wr
  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp,
                       input logic [31:0] mask);
    logic [31:0] rd;
    logic e;
    apb(1'b0, a, 32'h0, rd, e);
    chk(what, exp, rd & mask);
  endtask : rdChk
  task automatic st(input logic [31:0] exp);
    rdChk("status", SFS_ADDR_STATUS, exp, 32'h0020fffc);
  endtask : st
  initial begin
    #400000;
    nMismatch++;
    stopTest();
  end
  initial begin
    logic [31:0] d;
    logic v, e;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    arstN = 1'b0;
    repeat (16) @(posedge clk);
    arstN <= 1'b1;
    st(32'h0000f004);
    chk("sizeM1", 32'h1f, {27'h0, sizeM1});
    wr(SFS_ADDR_CTRL, 32'h00000703);
    wr(SFS_ADDR_THR, 32'h00000201);
    chk("portEnable", 32'h1, {31'h0, portEnable});
    chk("sizeM1", 32'h7, {27'h0, sizeM1});
    rdChk("ctrl", SFS_ADDR_CTRL, 32'h00000703, 32'h00201f03);
    st(32'h0000f024);
    for (int i = 0; i < 17; i++) begin
      if (i == 3) st(32'h0000f324);
      if (i == 4) st(32'h0000f404);
      wr(SFS_ADDR_DATA, 32'h300 | (i + 1));
    end
    st(32'h0000f000);
    for (int i = 0; i < 16; i++) begin
      u_ser.popWord(d, v);
      chk("txValid", 32'h1, {31'h0, v});
      chk("txData", {8'(i + 1), 24'h0}, d);
    end
    u_ser.popWord(d, v);
    chk("txValid", 32'h0, {31'h0, v});
    st(32'h0020f024);
    wr(SFS_ADDR_STATUS, 32'h00200000);
    st(32'h0000f024);
    u_ser.serBusy <= 1'b1;
    for (int i = 0; i < 17; i++) u_ser.pushWord(32'hab00 | (i + 1));
    st(32'h0000f0fc);
    chk("irq", 32'h1, {31'h0, irqReq});
    wr(SFS_ADDR_STATUS, 32'h00000080);
    st(32'h0000f07c);
    u_ser.serBusy <= 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (i == 14) st(32'h0000106c);
      if (i == 15) st(32'h0000002c);
      rdChk("rxData", SFS_ADDR_DATA, i + 1, 32'hffffffff);
    end
    st(32'h0000f024);
    wr(SFS_ADDR_DATA, 32'h1);
    wr(SFS_ADDR_DATA, 32'h2);
    st(32'h0000f224);
    wr(SFS_ADDR_CTRL, 32'h00000700);
    st(32'h0000f004);
    chk("txValid", 32'h0, {31'h0, serTxValid});
    chk("portEnable", 32'h0, {31'h0, portEnable});
    for (int k = 0; k < 3; k++) begin
      wr(SFS_ADDR_ITEST, 32'h20 << k);
      chk("itest", (k == 0) ? 3'b101 : (k == 1) ? 3'b110 : 3'b100,
          {irqReq, dmaRxReq, dmaTxReq});
    end
    wr(SFS_ADDR_ITEST, 32'h0);
    chk("itest", 32'h0, {irqReq, dmaRxReq, dmaTxReq});
    apb(1'b0, 8'h20, 32'h0, d, e);
    chk("slverr", 32'h1, {31'h0, e});
    chk("unmapped", 32'h0, d);
    stopTest();
  end
endmodule : sfs_top_tb
